// ===== mix_map.svh
`ifndef MIX_MAP_SVH
`define MIX_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define MIX_CMD_OFS      12'h000
`define MIX_WORK_OFS     12'h004
`define MIX_STATUS_OFS   12'h008
`define MIX_IP_OFS       12'h00c
`define MIX_OPTION_OFS   12'h010
`define MIX_PCTL5_OFS    12'h014
`define MIX_PCTL6_OFS    12'h018
`define MIX_WDG_OFS      12'h01c
`define MIX_TOS_OFS      12'h020
`define MIX_FILE_OFS     12'h100

// ****************************************
// command fields
// ****************************************
`define MIX_CMD_LIT_LSB  0
`define MIX_CMD_ADDR_LSB 8
`define MIX_CMD_DEST_BIT 14
`define MIX_CMD_OP_LSB   16

// ****************************************
// status bit positions
// ****************************************
`define MIX_ST_C         0
`define MIX_ST_HC        1
`define MIX_ST_Z         2
`define MIX_ST_PDN       3
`define MIX_ST_TO        4
`define MIX_ST_IEN       5
`define MIX_ST_SLEEP     6
`define MIX_ST_BUSY      7

// ****************************************
// reset values and counts
// ****************************************
`define MIX_STATUS_RST   8'h18
`define MIX_OPTION_RST   8'hff
`define MIX_PCTL_RST     8'hff
`define MIX_BRANCH_CYC   2
`define MIX_PCTL_LO      6'h05
`define MIX_PCTL_HI      6'h06

`endif

// ===== mix_pkg.sv
package mix_pkg;

  typedef enum logic [4:0] {
    MIX_OP_NOP, MIX_OP_OR_FILE, MIX_OP_OR_LIT, MIX_OP_PCTL_LOAD, MIX_OP_STORE_WORK,
    MIX_OP_LOAD_LIT, MIX_OP_COPY_FILE, MIX_OP_OPTION, MIX_OP_IRQ_RET, MIX_OP_RET_LIT,
    MIX_OP_RETURN, MIX_OP_ROT_LEFT, MIX_OP_ROT_RIGHT, MIX_OP_SLEEP, MIX_OP_SUB_BORROW,
    MIX_OP_SUB_FILE, MIX_OP_LIT_MINUS, MIX_OP_NIBBLE, MIX_OP_XOR_FILE, MIX_OP_XOR_LIT
  } mix_op_t;

  typedef struct packed {
    mix_op_t    op;
    logic       dest;
    logic [5:0] addr;
    logic [7:0] lit;
  } mix_cmd_t;

  typedef struct packed {
    logic c;
    logic hc;
    logic z;
  } mix_flags_t;

endpackage : mix_pkg

// ===== mix_exec.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mix_map.svh"
module mix_exec
  import mix_pkg::*;
#(
  parameter int FILE_DEPTH = 64,
  parameter int STACK_DEPTH = 5,
  parameter int IP_W = 10
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        sleep_mode,
  output var  logic [7:0]  option_out,
  output var  logic [7:0]  port_ctrl_a,
  output var  logic [7:0]  port_ctrl_b
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]      file_mem [FILE_DEPTH];
  logic [IP_W-1:0] stack_mem [STACK_DEPTH];
  logic [7:0]      working_register_reg;
  mix_flags_t      flags_reg;
  logic            timeout_bit_reg;
  logic            powerdown_flag_reg;
  logic            global_irq_allow_reg;
  logic [IP_W-1:0] instr_pointer_reg;
  logic [7:0]      watchdog_count_reg;
  logic [7:0]      wd_prescale_reg;
  localparam logic [7:0] status_rst = `MIX_STATUS_RST;
  logic [2:0]      sp_reg;
  logic [1:0]      busy_cnt_reg;
  mix_cmd_t        cmd;

  wire access  = psel & penable;
  wire wr_fire = access & pwrite;
  // compare one bit wider: a depth of 64 would wrap to zero in six bits
  wire file_hit = paddr[11:8] == 4'h1 && paddr[1:0] == 2'b00
                  && {1'b0, paddr[7:2]} < 7'(FILE_DEPTH);
  wire issue = wr_fire && paddr == `MIX_CMD_OFS && busy_cnt_reg == 2'd0 && !sleep_mode;

  assign cmd.op   = mix_op_t'(pwdata[`MIX_CMD_OP_LSB +: 5]);
  assign cmd.dest = pwdata[`MIX_CMD_DEST_BIT];
  assign cmd.addr = pwdata[`MIX_CMD_ADDR_LSB +: 6];
  assign cmd.lit  = pwdata[`MIX_CMD_LIT_LSB +: 8];

  wire [7:0] fval = file_mem[cmd.addr];
  wire [7:0] wval = working_register_reg;
  wire [2:0] tos_idx = (sp_reg == 3'd0) ? 3'(STACK_DEPTH - 1) : sp_reg - 3'd1;

  // ****************************************
  // datapath
  // ****************************************
  logic [7:0] res;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic       wr_work;
  logic       wr_file;
  logic       upd_z;
  logic       upd_c;
  logic       upd_arith;
  logic       new_c;
  logic [7:0] sub_a;
  logic       cin;

  always_comb begin
    res = 8'h00;
    wr_work = 1'b0;
    wr_file = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_arith = 1'b0;
    new_c = flags_reg.c;
    sub_a = fval;
    cin = 1'b1;
    case (cmd.op)
      MIX_OP_SUB_BORROW: cin = flags_reg.c;
      MIX_OP_LIT_MINUS:  sub_a = cmd.lit;
      default:           sub_a = fval;
    endcase
    // subtraction as addition of complement, carry set means no borrow
    sum = {1'b0, sub_a} + {1'b0, ~wval} + {8'h00, cin};
    hsum = {1'b0, sub_a[3:0]} + {1'b0, ~wval[3:0]} + {4'h0, cin};
    case (cmd.op)
      MIX_OP_OR_FILE: begin
        res = wval | fval;
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
        upd_z = 1'b1;
      end
      MIX_OP_OR_LIT: begin
        res = wval | cmd.lit;
        wr_work = 1'b1;
        upd_z = 1'b1;
      end
      MIX_OP_STORE_WORK: begin
        res = wval;
        wr_file = 1'b1;
      end
      MIX_OP_LOAD_LIT, MIX_OP_RET_LIT: begin
        res = cmd.lit;
        wr_work = 1'b1;
      end
      MIX_OP_COPY_FILE: begin
        res = fval;
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
        upd_z = 1'b1;
      end
      MIX_OP_ROT_LEFT: begin
        res = {fval[6:0], flags_reg.c};
        new_c = fval[7];
        upd_c = 1'b1;
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
      end
      MIX_OP_ROT_RIGHT: begin
        res = {flags_reg.c, fval[7:1]};
        new_c = fval[0];
        upd_c = 1'b1;
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
      end
      MIX_OP_SUB_BORROW, MIX_OP_SUB_FILE: begin
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
      end
      MIX_OP_LIT_MINUS: begin
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_work = 1'b1;
      end
      MIX_OP_NIBBLE: begin
        res = {fval[3:0], fval[7:4]};
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
      end
      MIX_OP_XOR_FILE: begin
        res = wval ^ fval;
        wr_work = !cmd.dest;
        wr_file = cmd.dest;
        upd_z = 1'b1;
      end
      MIX_OP_XOR_LIT: begin
        res = wval ^ cmd.lit;
        wr_work = 1'b1;
        upd_z = 1'b1;
      end
      default: res = 8'h00;
    endcase
  end

  // ****************************************
  // working register and flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register_reg <= 8'h00;
    end else if (issue && wr_work) begin
      working_register_reg <= res;
    end else if (wr_fire && paddr == `MIX_WORK_OFS) begin
      working_register_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else if (issue && upd_arith) begin
      flags_reg.c  <= sum[8];
      flags_reg.hc <= hsum[4];
      flags_reg.z  <= res == 8'h00;
    end else if (issue && upd_c) begin
      flags_reg.c <= new_c;
    end else if (issue && upd_z) begin
      flags_reg.z <= res == 8'h00;
    end else if (wr_fire && paddr == `MIX_STATUS_OFS) begin
      flags_reg.c  <= pwdata[`MIX_ST_C];
      flags_reg.hc <= pwdata[`MIX_ST_HC];
      flags_reg.z  <= pwdata[`MIX_ST_Z];
    end
  end

  // ****************************************
  // file registers
  // ****************************************
  always_ff @(posedge pclk) begin
    if (issue && wr_file) begin
      file_mem[cmd.addr] <= res;
    end else if (wr_fire && file_hit) begin
      file_mem[paddr[7:2]] <= pwdata[7:0];
    end
  end

  // ****************************************
  // option and port control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_out <= `MIX_OPTION_RST;
    end else if (issue && cmd.op == MIX_OP_OPTION) begin
      option_out <= wval;
    end
  end

  // other addresses are dropped: only 5 and 6 hold port control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_ctrl_a <= `MIX_PCTL_RST;
      port_ctrl_b <= `MIX_PCTL_RST;
    end else if (issue && cmd.op == MIX_OP_PCTL_LOAD) begin
      if (cmd.addr == `MIX_PCTL_LO) port_ctrl_a <= wval;
      if (cmd.addr == `MIX_PCTL_HI) port_ctrl_b <= wval;
    end
  end

  // ****************************************
  // stack, pointer and return timing
  // ****************************************
  wire is_ret = cmd.op == MIX_OP_IRQ_RET || cmd.op == MIX_OP_RET_LIT || cmd.op == MIX_OP_RETURN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_pointer_reg <= '0;
      sp_reg <= 3'd0;
      busy_cnt_reg <= 2'd0;
    end else if (issue && is_ret) begin
      instr_pointer_reg <= stack_mem[tos_idx];
      sp_reg <= tos_idx;
      busy_cnt_reg <= 2'(`MIX_BRANCH_CYC - 1);
    end else if (issue) begin
      instr_pointer_reg <= instr_pointer_reg + 1'b1;
    end else if (busy_cnt_reg != 2'd0) begin
      busy_cnt_reg <= busy_cnt_reg - 2'd1;
    end else if (wr_fire && paddr == `MIX_TOS_OFS) begin
      // test push so software can seed return addresses
      sp_reg <= (sp_reg == 3'(STACK_DEPTH - 1)) ? 3'd0 : sp_reg + 3'd1;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_fire && paddr == `MIX_TOS_OFS && busy_cnt_reg == 2'd0 && !issue) begin
      stack_mem[sp_reg] <= pwdata[IP_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_allow_reg <= 1'b0;
    end else if (issue && cmd.op == MIX_OP_IRQ_RET) begin
      global_irq_allow_reg <= 1'b1;
    end else if (wr_fire && paddr == `MIX_STATUS_OFS) begin
      global_irq_allow_reg <= pwdata[`MIX_ST_IEN];
    end
  end

  // ****************************************
  // sleep and watchdog
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_count_reg <= 8'h00;
      wd_prescale_reg <= 8'h00;
      timeout_bit_reg <= status_rst[`MIX_ST_TO];
      powerdown_flag_reg <= status_rst[`MIX_ST_PDN];
      sleep_mode <= 1'b0;
    end else if (issue && cmd.op == MIX_OP_SLEEP) begin
      watchdog_count_reg <= 8'h00;
      wd_prescale_reg <= 8'h00;
      timeout_bit_reg <= 1'b1;
      powerdown_flag_reg <= 1'b0;
      sleep_mode <= 1'b1;
    end else if (wr_fire && paddr == `MIX_WDG_OFS) begin
      // wake is by software only; no wake sources live in this block
      sleep_mode <= pwdata[0] ? 1'b0 : sleep_mode;
    end else if (!sleep_mode) begin
      {watchdog_count_reg, wd_prescale_reg} <= {watchdog_count_reg, wd_prescale_reg} + 16'h0001;
    end
  end

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  logic [31:0] rd_mux;
  logic        addr_ok;

  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      `MIX_CMD_OFS:    rd_mux = 32'h0000_0000;
      `MIX_WORK_OFS:   rd_mux = {24'h000000, working_register_reg};
      `MIX_STATUS_OFS: rd_mux = {24'h000000, busy_cnt_reg != 2'd0, sleep_mode,
                                 global_irq_allow_reg, timeout_bit_reg, powerdown_flag_reg,
                                 flags_reg.z, flags_reg.hc, flags_reg.c};
      `MIX_IP_OFS:     rd_mux = 32'(instr_pointer_reg);
      `MIX_OPTION_OFS: rd_mux = {24'h000000, option_out};
      `MIX_PCTL5_OFS:  rd_mux = {24'h000000, port_ctrl_a};
      `MIX_PCTL6_OFS:  rd_mux = {24'h000000, port_ctrl_b};
      `MIX_WDG_OFS:    rd_mux = {16'h0000, watchdog_count_reg, wd_prescale_reg};
      `MIX_TOS_OFS:    rd_mux = 32'(stack_mem[tos_idx]);
      default: begin
        if (file_hit) rd_mux = {24'h000000, file_mem[paddr[7:2]]};
        else addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : mix_exec
`default_nettype wire

// ===== mix_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mix_map.svh"
module mix_exec_chk
  import mix_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_mode,
  input wire logic [7:0]  option_out,
  input wire logic [7:0]  port_ctrl_a,
  input wire logic [7:0]  port_ctrl_b
);
  // ****************************************
  // apb timing and command side effects
  // ****************************************
  logic cmd_go;
  logic opt_go;
  logic pa_go;
  logic pb_go;
  logic slp_go;
  logic wake_go;
  assign cmd_go  = psel && penable && pready && pwrite && paddr == `MIX_CMD_OFS;
  assign opt_go  = cmd_go && pwdata[20:16] == MIX_OP_OPTION;
  assign pa_go   = cmd_go && pwdata[20:16] == MIX_OP_PCTL_LOAD && pwdata[13:8] == `MIX_PCTL_LO;
  assign pb_go   = cmd_go && pwdata[20:16] == MIX_OP_PCTL_LOAD && pwdata[13:8] == `MIX_PCTL_HI;
  assign slp_go  = cmd_go && pwdata[20:16] == MIX_OP_SLEEP;
  assign wake_go = psel && penable && pready && pwrite && paddr == `MIX_WDG_OFS && pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no ready one cycle after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside access");
  chk_unmapped_err: assert property (s_setup and paddr inside {[12'h024:12'h0ff]} |=> pslverr)
    else $error("unmapped address not flagged");
  // one cycle of slack: the update may land at or just after the taken edge
  chk_option_cause: assert property ($changed(option_out) |-> $past(opt_go) || $past(opt_go, 2))
    else $error("option changed without its command");
  chk_pctl_a_cause: assert property ($changed(port_ctrl_a) |-> $past(pa_go) || $past(pa_go, 2))
    else $error("port control a changed without its command");
  chk_pctl_b_cause: assert property ($changed(port_ctrl_b) |-> $past(pb_go) || $past(pb_go, 2))
    else $error("port control b changed without its command");
  chk_sleep_entry: assert property ($rose(sleep_mode) |-> $past(slp_go) || $past(slp_go, 2))
    else $error("sleep entered without its command");
  chk_sleep_holds: assert property (sleep_mode && !wake_go |=> sleep_mode)
    else $error("sleep left without wake write");
endmodule : mix_exec_chk

bind mix_exec mix_exec_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_mode(sleep_mode), .option_out(option_out), .port_ctrl_a(port_ctrl_a),
  .port_ctrl_b(port_ctrl_b)
);
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mix_map.svh"
module testbench;
  import mix_pkg::*;
  // ****************************************
  // bench signals and access tasks
  // ****************************************
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_mode;
  logic [7:0]  option_out;
  logic [7:0]  port_ctrl_a;
  logic [7:0]  port_ctrl_b;
  logic [31:0] rd;
  logic        err;
  logic [31:0] p;
  int          fails = 0;
  int          comparisons = 0;
  localparam logic [11:0] wk = `MIX_WORK_OFS;
  localparam logic [11:0] st = `MIX_STATUS_OFS;
  localparam logic [11:0] ip = `MIX_IP_OFS;
  localparam logic [11:0] wd = `MIX_WDG_OFS;
  localparam logic [11:0] ts = `MIX_TOS_OFS;
  always #50 pclk = ~pclk;
  mix_exec u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .option_out(option_out), .port_ctrl_a(port_ctrl_a),
    .port_ctrl_b(port_ctrl_b)
  );
  task automatic final_report;
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // bounded wait: a stuck slave ends the run instead of hanging it
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("CHECK FAILED t=%0t no ready", $time);
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check({31'h0, err}, 32'h0);
  endtask : rdc
  // extra cycle lets the busy bit of two-cycle returns clear
  task automatic cmd(input mix_op_t op, input logic d, input logic [5:0] r, input logic [7:0] l);
    apb(1'b1, `MIX_CMD_OFS, {11'h0, op, 1'b0, d, r, l});
    @(posedge pclk);
  endtask : cmd
  function automatic logic [11:0] fa(input logic [5:0] r);
    return `MIX_FILE_OFS + {4'h0, r, 2'b00};
  endfunction : fa
  task automatic setw(input logic [7:0] v);
    cmd(MIX_OP_LOAD_LIT, 1'b0, 6'h00, v);
  endtask : setw
  task automatic setf(input logic [5:0] r, input logic [7:0] v);
    setw(v);
    cmd(MIX_OP_STORE_WORK, 1'b0, r, 8'h00);
  endtask : setf
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(st, 32'h18);
    setw(8'ha5);
    rdc(wk, 32'ha5);
    rdc(st, 32'h18);
    cmd(MIX_OP_STORE_WORK, 1'b0, 6'h3f, 8'h00);
    rdc(fa(6'h3f), 32'ha5);
    setf(6'h03, 8'h30);
    setw(8'h0f);
    cmd(MIX_OP_OR_FILE, 1'b1, 6'h03, 8'h00);
    rdc(fa(6'h03), 32'h3f);
    rdc(wk, 32'h0f);
    cmd(MIX_OP_OR_FILE, 1'b0, 6'h03, 8'h00);
    rdc(wk, 32'h3f);
    setw(8'h00);
    cmd(MIX_OP_OR_LIT, 1'b0, 6'h00, 8'h00);
    rdc(st, 32'h1c);
    apb(1'b0, ip, 32'h0);
    p = rd;
    cmd(MIX_OP_OR_LIT, 1'b0, 6'h00, 8'h80);
    rdc(wk, 32'h80);
    rdc(st, 32'h18);
    rdc(ip, (p + 32'h1) & 32'h3ff);
    cmd(MIX_OP_XOR_LIT, 1'b0, 6'h00, 8'h80);
    rdc(wk, 32'h00);
    rdc(st, 32'h1c);
    setf(6'h04, 8'h55);
    setw(8'hff);
    cmd(MIX_OP_XOR_FILE, 1'b1, 6'h04, 8'h00);
    rdc(fa(6'h04), 32'haa);
    rdc(st, 32'h18);
    setf(6'h05, 8'h00);
    cmd(MIX_OP_COPY_FILE, 1'b1, 6'h05, 8'h00);
    rdc(st, 32'h1c);
    cmd(MIX_OP_COPY_FILE, 1'b0, 6'h03, 8'h00);
    rdc(wk, 32'h3f);
    setw(8'h12);
    cmd(MIX_OP_PCTL_LOAD, 1'b0, 6'h05, 8'h00);
    setw(8'h34);
    cmd(MIX_OP_PCTL_LOAD, 1'b0, 6'h06, 8'h00);
    setw(8'h56);
    cmd(MIX_OP_PCTL_LOAD, 1'b0, 6'h07, 8'h00);
    cmd(MIX_OP_OPTION, 1'b0, 6'h00, 8'h00);
    rdc(st, 32'h18);
    check({24'h0, port_ctrl_a}, 32'h12);
    check({24'h0, port_ctrl_b}, 32'h34);
    check({24'h0, option_out}, 32'h56);
    apb(1'b1, st, 32'h04);
    setf(6'h06, 8'h81);
    cmd(MIX_OP_ROT_LEFT, 1'b0, 6'h06, 8'h00);
    rdc(wk, 32'h02);
    rdc(st, 32'h1d);
    setf(6'h07, 8'h02);
    cmd(MIX_OP_ROT_RIGHT, 1'b1, 6'h07, 8'h00);
    rdc(fa(6'h07), 32'h81);
    rdc(st, 32'h1c);
    setf(6'h08, 8'h05);
    setw(8'h03);
    cmd(MIX_OP_SUB_FILE, 1'b0, 6'h08, 8'h00);
    rdc(wk, 32'h02);
    rdc(st, 32'h1b);
    setf(6'h09, 8'h03);
    setw(8'h05);
    cmd(MIX_OP_SUB_FILE, 1'b1, 6'h09, 8'h00);
    rdc(fa(6'h09), 32'hfe);
    rdc(st, 32'h18);
    setw(8'h01);
    cmd(MIX_OP_LIT_MINUS, 1'b0, 6'h00, 8'h10);
    rdc(wk, 32'h0f);
    rdc(st, 32'h19);
    setf(6'h0a, 8'h05);
    setw(8'h03);
    cmd(MIX_OP_SUB_BORROW, 1'b0, 6'h0a, 8'h00);
    rdc(wk, 32'h02);
    apb(1'b1, st, 32'h00);
    setw(8'h01);
    cmd(MIX_OP_SUB_BORROW, 1'b0, 6'h0a, 8'h00);
    rdc(wk, 32'h03);
    rdc(st, 32'h1b);
    setf(6'h0b, 8'h5a);
    cmd(MIX_OP_NIBBLE, 1'b0, 6'h0b, 8'h00);
    rdc(wk, 32'ha5);
    rdc(st, 32'h1b);
    apb(1'b1, ts, 32'h123);
    cmd(MIX_OP_IRQ_RET, 1'b0, 6'h00, 8'h00);
    rdc(ip, 32'h123);
    rdc(st, 32'h3b);
    apb(1'b1, ts, 32'h045);
    cmd(MIX_OP_RET_LIT, 1'b0, 6'h00, 8'h77);
    rdc(ip, 32'h045);
    rdc(wk, 32'h77);
    apb(1'b1, ts, 32'h200);
    cmd(MIX_OP_RETURN, 1'b0, 6'h00, 8'h00);
    rdc(ip, 32'h200);
    rdc(st, 32'h3b);
    cmd(MIX_OP_SLEEP, 1'b0, 6'h00, 8'h00);
    rdc(wd, 32'h0);
    rdc(st, 32'h73);
    check({31'h0, sleep_mode}, 32'h1);
    setw(8'hee);
    rdc(wk, 32'h77);
    apb(1'b1, wd, 32'h1);
    rdc(`MIX_CMD_OFS, 32'h0);
    check({31'h0, sleep_mode}, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    check({31'h0, err}, 32'h1);
    final_report();
  end
endmodule : testbench
`default_nettype wire
